/* File: hw/dsc_decode_regs.svh */
// field positions, class codes and cycle counts of the instruction decoder
// assumes 24-bit program words with the opcode in the top byte
`ifndef DSC_DECODE_REGS_SVH
`define DSC_DECODE_REGS_SVH

`define DSC_WORD_W 24
`define DSC_OPC_HI 23
`define DSC_OPC_LO 16
`define DSC_CLS_HI 23
`define DSC_CLS_LO 20
`define DSC_OPC_ZERO 8'h00
`define DSC_AWB_BIT 16
`define DSC_ACC_BIT 15
`define DSC_BYTE_BIT 14
`define DSC_DEST_BIT 13
`define DSC_BIT_IND_BIT 4
`define DSC_FILE_MAX 13'h1fff
`define DSC_TEN_BIT_LITERAL_BYTE_MAX 10'h0ff
`define DSC_MUL_CODE_MAX 3'h5
`define DSC_DEFAULT_WORKING_REG_IDX 4'h0
`define DSC_W4_IDX 4'h4
`define DSC_W13_IDX 4'hd
`define DSC_W12_IDX 4'hc

`define DSC_CLS_NOP 4'h0
`define DSC_CLS_FILE 4'h1
`define DSC_CLS_LIT 4'h2
`define DSC_CLS_BIT 4'h3
`define DSC_CLS_SKIP 4'h4
`define DSC_CLS_BRC 4'h5
`define DSC_CLS_BRA 4'h6
`define DSC_CLS_DBL 4'h7
`define DSC_CLS_MOVD 4'h8
`define DSC_CLS_TBL 4'h9
`define DSC_CLS_MAC 4'ha
`define DSC_CLS_SQR 4'hb
`define DSC_CLS_ACC 4'hc

`define DSC_CYC_SINGLE 3'h1
`define DSC_CYC_DOUBLE 3'h2
`define DSC_CYC_SKIP1 3'h2
`define DSC_CYC_SKIP2 3'h3
`define DSC_CYC_FLOW 3'h4
`define DSC_CYC_MOVD 3'h2
`define DSC_CYC_TBL 3'h2

`endif

/* File: hw/dsc_decode_pkg.sv */
// types shared by the instruction decoder and its prefetch field decoder
// assumes nothing beyond a SystemVerilog compiler
package dsc_decode_pkg;

  typedef enum logic [3:0] {
    CLS_NOP, CLS_FILE, CLS_LIT, CLS_BIT, CLS_SKIP, CLS_BRC, CLS_BRA,
    CLS_DBL, CLS_MOVD, CLS_TBL, CLS_MAC, CLS_SQR, CLS_ACC, CLS_ILLEGAL
  } cls_t;

  typedef enum logic {AWB_W13, AWB_W13_IND_POSTINC} awb_t;

  typedef struct packed {
    logic [3:0] base_reg;
    logic signed [3:0] adjust;
    logic indexed;
    logic none;
  } pf_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic negative;
    logic overflow;
    logic zero;
    logic acc_a_ovf;
    logic acc_b_ovf;
    logic acc_a_sat;
    logic acc_b_sat;
  } flag_upd_t;

  typedef struct packed {
    cls_t cls;
    logic [7:0] opcode;
    logic byte_mode;
    logic [3:0] dest_operand_reg;
    logic dest_to_default_working_reg;
    logic [12:0] file_addr;
    logic [3:0] bit_position_field;
    logic bit_indirect;
    logic [3:0] base_operand_reg;
    logic [9:0] ten_bit_literal;
    logic [22:0] program_addr_literal;
    logic acc_sel;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    pf_t x_prefetch_addr_sel;
    pf_t y_prefetch_addr_sel;
    logic [3:0] x_prefetch_dest;
    logic [3:0] y_prefetch_dest;
    awb_t acc_writeback_target;
    flag_upd_t flags;
    logic [2:0] cycles;
    logic illegal;
  } dec_t;

endpackage

/* File: hw/dsc_prefetch_field.sv */
// decodes one 4-bit dual-fetch address field into base, adjust and mode
// assumes the caller picks the register pair through BASE_LO
`timescale 1ns/1ps
`default_nettype none
`include "dsc_decode_regs.svh"

module dsc_prefetch_field #(
  parameter logic [3:0] BASE_LO = 4'h8
) (
  // field in
  input wire logic [3:0] field,
  // decoded out
  output var dsc_decode_pkg::pf_t pf
);
  import dsc_decode_pkg::*;

  // codes 0..6 lower reg, 8..14 upper reg, 7 indexed, 15 none
  wire [2:0] adj_code = field[2:0];
  wire is_indexed = (field == 4'h7);
  wire is_none = (field == 4'hf);
  wire logic signed [3:0] adj_val =
    (adj_code == 3'h1) ? 4'sh2 :
    (adj_code == 3'h2) ? 4'sh4 :
    (adj_code == 3'h3) ? 4'sh6 :
    (adj_code == 3'h4) ? -4'sh6 :
    (adj_code == 3'h5) ? -4'sh4 :
    (adj_code == 3'h6) ? -4'sh2 : 4'sh0;

  assign pf.base_reg = is_indexed ? BASE_LO + 4'h1 : BASE_LO + {3'h0, field[3]};
  assign pf.adjust = (is_indexed || is_none) ? 4'sh0 : adj_val;
  assign pf.indexed = is_indexed;
  assign pf.none = is_none;
endmodule

`default_nettype wire

/* File: hw/dsc_instruction_format_decoder.sv */
// instruction word format decoder: splits program words into fields,
// joins double-word instructions and paces the instruction cycles
// assumes fetch presents the following word on peek_word, and the
// datapath reports the conditional test of the word being taken
`timescale 1ns/1ps
`default_nettype none
`include "dsc_decode_regs.svh"

module dsc_instruction_format_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // fetch side
  input wire logic fetch_valid,
  input wire logic [23:0] fetch_word,
  input wire logic [23:0] peek_word,
  output logic fetch_ready,
  // execute side
  input wire logic cond_true,
  output logic dec_valid,
  output logic dec_nop,
  output var dsc_decode_pkg::dec_t dec
);
  import dsc_decode_pkg::*;

  typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_STALL} state_t;

  state_t state_reg, state_next;
  logic [2:0] stall_cnt_reg, stall_cnt_next;
  logic [23:0] first_word_reg;
  logic dec_valid_reg, dec_nop_reg;
  dec_t dec_reg, dec_next;

  function automatic cls_t classify(input logic [7:0] opc);
    cls_t c;
    c = CLS_ILLEGAL;
    // lone tail word decodes as no-op
    if (opc == `DSC_OPC_ZERO)
      c = CLS_NOP;
    else
      case (opc[7:4])
        `DSC_CLS_NOP: c = CLS_NOP;
        `DSC_CLS_FILE: c = CLS_FILE;
        `DSC_CLS_LIT: c = CLS_LIT;
        `DSC_CLS_BIT: c = CLS_BIT;
        `DSC_CLS_SKIP: c = CLS_SKIP;
        `DSC_CLS_BRC: c = CLS_BRC;
        `DSC_CLS_BRA: c = CLS_BRA;
        `DSC_CLS_DBL: c = CLS_DBL;
        `DSC_CLS_MOVD: c = CLS_MOVD;
        `DSC_CLS_TBL: c = CLS_TBL;
        `DSC_CLS_MAC: c = CLS_MAC;
        `DSC_CLS_SQR: c = CLS_SQR;
        `DSC_CLS_ACC: c = CLS_ACC;
        default: c = CLS_ILLEGAL;
      endcase
    return c;
  endfunction

  // field split of the word being taken
  // opcode top byte
  wire [7:0] opc = fetch_word[`DSC_OPC_HI:`DSC_OPC_LO];
  wire cls_t cls_w = classify(opc);
  wire cls_t cls_first = classify(first_word_reg[`DSC_OPC_HI:`DSC_OPC_LO]);
  wire peek_double = (classify(peek_word[`DSC_OPC_HI:`DSC_OPC_LO]) == CLS_DBL);
  wire take = fetch_valid && fetch_ready;
  wire is_dbl = (cls_w == CLS_DBL);

  // skip length follows skipped word size
  wire [2:0] cycles_single =
    (cls_w == CLS_SKIP && cond_true) ? (peek_double ? `DSC_CYC_SKIP2 : `DSC_CYC_SKIP1) :
    (cls_w == CLS_BRC && cond_true) ? `DSC_CYC_FLOW :
    (cls_w == CLS_BRA) ? `DSC_CYC_FLOW :
    (cls_w == CLS_MOVD) ? `DSC_CYC_MOVD :
    (cls_w == CLS_TBL) ? `DSC_CYC_TBL : `DSC_CYC_SINGLE;

  wire ten_bit_literal_bad = (cls_w == CLS_LIT) && fetch_word[`DSC_BYTE_BIT] &&
    (fetch_word[13:4] > `DSC_TEN_BIT_LITERAL_BYTE_MAX);
  // multiply pair codes above five are unused
  wire mul_bad = (cls_w == CLS_MAC) && (fetch_word[14:12] > `DSC_MUL_CODE_MAX);
  wire [3:0] mul_a_w =
    (fetch_word[14:12] < 3'h3) ? 4'h4 : (fetch_word[14:12] < 3'h5) ? 4'h5 : 4'h6;
  wire [3:0] mul_b_w =
    (fetch_word[14:12] == 3'h0) ? 4'h5 :
    (fetch_word[14:12] == 3'h1 || fetch_word[14:12] == 3'h3) ? 4'h6 : 4'h7;
  wire [3:0] sqr_w = `DSC_W4_IDX + {2'h0, fetch_word[13:12]};
  // second word must carry a zero top byte
  wire second_bad = (fetch_word[`DSC_OPC_HI:`DSC_OPC_LO] != `DSC_OPC_ZERO);
  wire [22:0] addr_dbl = {fetch_word[6:0], first_word_reg[15:0]};
  wire addr_bad = addr_dbl[0];

  pf_t x_pf, y_pf;

  // X side uses W8/W9, Y side W10/W11
  dsc_prefetch_field #(.BASE_LO(4'h8)) x_field (
    .field(fetch_word[11:8]),
    .pf(x_pf)
  );
  dsc_prefetch_field #(.BASE_LO(4'ha)) y_field (
    .field(fetch_word[7:4]),
    .pf(y_pf)
  );

  wire arith = (cls_w == CLS_FILE) || (cls_w == CLS_LIT);
  wire dsp = (cls_w == CLS_MAC) || (cls_w == CLS_SQR) || (cls_w == CLS_ACC);

  always_comb
  begin
    dec_next = '0;
    dec_next.opcode = opc;
    dec_next.cls = cls_w;
    dec_next.byte_mode = fetch_word[`DSC_BYTE_BIT];
    dec_next.dest_to_default_working_reg = (cls_w == CLS_FILE) && fetch_word[`DSC_DEST_BIT];
    dec_next.dest_operand_reg = `DSC_DEFAULT_WORKING_REG_IDX;
    dec_next.file_addr = fetch_word[12:0] & `DSC_FILE_MAX;
    dec_next.bit_position_field = fetch_word[3:0];
    dec_next.bit_indirect = (cls_w == CLS_BIT) && fetch_word[`DSC_BIT_IND_BIT];
    dec_next.base_operand_reg = fetch_word[11:8];
    dec_next.ten_bit_literal = fetch_word[13:4];
    dec_next.acc_sel = fetch_word[`DSC_ACC_BIT];
    dec_next.mul_a = (cls_w == CLS_SQR) ? sqr_w : mul_a_w;
    dec_next.mul_b = (cls_w == CLS_SQR) ? sqr_w : mul_b_w;
    dec_next.x_prefetch_addr_sel = x_pf;
    dec_next.y_prefetch_addr_sel = y_pf;
    dec_next.x_prefetch_dest = `DSC_W4_IDX + {2'h0, fetch_word[3:2]};
    dec_next.y_prefetch_dest = `DSC_W4_IDX + {2'h0, fetch_word[1:0]};
    dec_next.acc_writeback_target = fetch_word[`DSC_AWB_BIT] ? AWB_W13_IND_POSTINC : AWB_W13;
    dec_next.flags = '{arith, arith, arith, arith, arith, dsp, dsp, dsp, dsp};
    dec_next.cycles = cycles_single;
    dec_next.illegal = ten_bit_literal_bad || mul_bad || (cls_w == CLS_ILLEGAL);
    if (state_reg == ST_SECOND)
    begin
      dec_next.opcode = first_word_reg[`DSC_OPC_HI:`DSC_OPC_LO];
      dec_next.cls = cls_first;
      dec_next.flags = '0;
      dec_next.program_addr_literal = addr_dbl;
      dec_next.cycles = `DSC_CYC_DOUBLE;
      dec_next.illegal = second_bad || addr_bad;
    end
  end

  // stalls while extra cycles run as no-ops
  assign fetch_ready = clk_en && (state_reg != ST_STALL);
  assign dec_valid = dec_valid_reg;
  assign dec_nop = dec_nop_reg;
  assign dec = dec_reg;

  always_comb
  begin
    state_next = state_reg;
    stall_cnt_next = stall_cnt_reg;
    unique case (state_reg)
      ST_FIRST:
        if (take && is_dbl)
          state_next = ST_SECOND;
        else if (take && cycles_single != `DSC_CYC_SINGLE)
        begin
          state_next = ST_STALL;
          stall_cnt_next = cycles_single - 3'h1;
        end
      ST_SECOND:
        if (take)
          state_next = ST_FIRST;
      ST_STALL:
      begin
        stall_cnt_next = stall_cnt_reg - 3'h1;
        if (stall_cnt_reg == 3'h1)
          state_next = ST_FIRST;
      end
    endcase
  end

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      state_reg <= ST_FIRST;
      stall_cnt_reg <= 3'h0;
      dec_valid_reg <= 1'b0;
      dec_nop_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      stall_cnt_reg <= stall_cnt_next;
      dec_valid_reg <= take && !(state_reg == ST_FIRST && is_dbl);
      dec_nop_reg <= (state_reg == ST_STALL);
    end

  // data path also cleared by reset, qualified by dec_valid
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      first_word_reg <= 24'h000000;
      dec_reg <= '0;
    end
    else if (clk_en && take)
    begin
      if (state_reg == ST_FIRST && is_dbl)
        first_word_reg <= fetch_word;
      else
        dec_reg <= dec_next;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_OPCODE_FIELD: assert property (
    (state_reg == ST_FIRST && take && !is_dbl) |=> dec_reg.opcode == $past(opc))
    else $error("opcode not taken from top byte");
  AST_SECOND_ZERO: assert property (
    (state_reg == ST_SECOND && take && second_bad) |=> dec_valid_reg && dec_reg.illegal)
    else $error("nonzero second word top byte not flagged");
  AST_ORPHAN_NOP: assert property (
    (state_reg == ST_FIRST && take && opc == `DSC_OPC_ZERO) |=> dec_reg.cls == CLS_NOP)
    else $error("lone second word not a no-op");
  AST_DBL_TWO: assert property (
    (state_reg == ST_FIRST && take && is_dbl) |=> state_reg == ST_SECOND && !dec_valid_reg)
    else $error("double word did not wait for second word");
  AST_DBL_CYCLES: assert property (
    (state_reg == ST_SECOND && take) |=> dec_valid_reg && dec_reg.cycles == 3'h2)
    else $error("double word not two cycles");
  AST_STALL_NOP: assert property (
    (state_reg == ST_STALL && clk_en) |=> dec_nop_reg && !dec_valid_reg)
    else $error("extra cycle not a no-op");
  AST_SKIP_LEN: assert property (
    (state_reg == ST_FIRST && take && cls_w == CLS_SKIP && cond_true && peek_double)
      |=> dec_reg.cycles == 3'h3 && stall_cnt_reg == 3'h2)
    else $error("skip over double word not three cycles");
  AST_MOVD: assert property (
    (state_reg == ST_FIRST && take && cls_w == CLS_MOVD)
      |=> state_reg == ST_STALL ##1 (clk_en ? state_reg == ST_FIRST : 1'b1))
    else $error("double move not two cycles");
  AST_LIT_RANGE: assert property (
    (state_reg == ST_FIRST && take && ten_bit_literal_bad) |=> dec_reg.illegal)
    else $error("byte literal above 255 not flagged");
  AST_ADDR_EVEN: assert property (
    (state_reg == ST_SECOND && take && addr_bad) |=> dec_reg.illegal)
    else $error("odd program address not flagged");
  AST_MUL_PAIR: assert property (
    (dec_valid_reg && dec_reg.cls == CLS_MAC && !dec_reg.illegal)
      |-> dec_reg.mul_a < dec_reg.mul_b && dec_reg.mul_a >= 4'h4 && dec_reg.mul_b <= 4'h7)
    else $error("illegal multiply pair");
  AST_DEST_SEL: assert property (
    (state_reg == ST_FIRST && take && cls_w == CLS_FILE)
      |=> dec_reg.dest_to_default_working_reg == $past(fetch_word[`DSC_DEST_BIT])
        && dec_reg.dest_operand_reg == `DSC_DEFAULT_WORKING_REG_IDX)
    else $error("file result destination wrong");
  AST_FILE_ADDR: assert property (
    (state_reg == ST_FIRST && take && cls_w == CLS_FILE)
      |=> dec_reg.file_addr == $past(fetch_word[12:0]))
    else $error("file address not taken whole");
  AST_BIT_SEL: assert property (
    (state_reg == ST_FIRST && take && cls_w == CLS_BIT)
      |=> dec_reg.bit_position_field == $past(fetch_word[3:0])
        && dec_reg.bit_indirect == $past(fetch_word[`DSC_BIT_IND_BIT]))
    else $error("bit position not taken from word");
  AST_PF_ADDR: assert property (
    (state_reg == ST_FIRST && take && dsp)
      |=> dec_reg.x_prefetch_addr_sel.base_reg[3:1] == 3'h4
        && dec_reg.y_prefetch_addr_sel.base_reg[3:1] == 3'h5)
    else $error("prefetch address register outside its pair");
  AST_PF_DEST: assert property (
    (state_reg == ST_FIRST && take && dsp)
      |=> dec_reg.x_prefetch_dest[3:2] == 2'h1 && dec_reg.y_prefetch_dest[3:2] == 2'h1)
    else $error("prefetch destination outside four to seven");
  AST_AWB: assert property (
    (state_reg == ST_FIRST && take && dsp)
      |=> (dec_reg.acc_writeback_target == AWB_W13_IND_POSTINC)
        == $past(fetch_word[`DSC_AWB_BIT]))
    else $error("write-back target not from its bit");
  AST_FLAGS: assert property (
    (state_reg == ST_FIRST && take && (arith || dsp))
      |=> dec_reg.flags.carry == $past(arith) && dec_reg.flags.acc_a_sat == $past(dsp))
    else $error("flag update mask wrong for class");
  AST_ACC_SEL: assert property (
    (state_reg == ST_FIRST && take && dsp)
      |=> dec_reg.acc_sel == $past(fetch_word[`DSC_ACC_BIT]))
    else $error("accumulator select not from its bit");

  COV_DOUBLE: cover property (state_reg == ST_SECOND && take);
  COV_SKIP3: cover property (dec_valid_reg && dec_reg.cls == CLS_SKIP && dec_reg.cycles == 3'h3);
  COV_BRANCH: cover property (dec_valid_reg && dec_reg.cls == CLS_BRC && dec_reg.cycles == 3'h4);
  COV_ORPHAN: cover property (state_reg == ST_FIRST && take && opc == `DSC_OPC_ZERO);
endmodule

`default_nettype wire

/* File: tb/fetch_mem_model.sv */
// program memory fetch path: offers load_len words in order, of which only the first two are loaded
// assumes the bench pulses load for one clock between runs
`timescale 1ns/1ps
`default_nettype none

module fetch_mem_model (
  // clock
  input wire logic clk,
  // loading by the bench
  input wire logic load,
  input wire logic [23:0] load_w0,
  input wire logic [23:0] load_w1,
  input wire logic [2:0] load_len,
  // fetch handshake
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [23:0] fetch_word,
  output logic [23:0] peek_word
);
  logic [23:0] mem [0:3] = '{default: 24'h0};
  int ptr = 0;
  int len = 0;
  logic [23:0] idle_pat = 24'h5a5a5a;

  // idle bus toggles so a stale word never passes for a real one
  always @(posedge clk)
  begin
    idle_pat <= ~idle_pat;
    if (load)
    begin
      mem[0] <= load_w0;
      mem[1] <= load_w1;
      ptr <= 0;
      len <= int'(load_len);
    end
    else if (fetch_valid && fetch_ready)
      ptr <= ptr + 1;
  end

  // words handed over whole, in order
  assign fetch_valid = ptr < len;
  assign fetch_word = fetch_valid ? mem[ptr] : idle_pat;
  assign peek_word = (ptr < 3) ? mem[ptr + 1] : idle_pat;
endmodule

`default_nettype wire

/* File: tb/dsc_instruction_format_decoder_test.sv */
// bench for the instruction decoder, fed by the fetch model
// assumes one clock at 100 MHz and a synchronous reset
`timescale 1ns/1ps
`default_nettype none

module dsc_instruction_format_decoder_test;
  import dsc_decode_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic clk_en = 1;
  logic cond_true = 0;
  logic fetch_valid, fetch_ready, dec_valid, dec_nop;
  logic [23:0] fetch_word, peek_word;
  dec_t dec;
  dec_t d;
  logic load = 1'b0;
  logic [23:0] load_w0 = 24'h0;
  logic [23:0] load_w1 = 24'h0;
  logic [2:0] load_len = 3'h0;
  int got, nops;
  int cyc = 0;
  int n_fail = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  fetch_mem_model mdl (.clk(clk), .load(load), .load_w0(load_w0), .load_w1(load_w1),
    .load_len(load_len), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .peek_word(peek_word));

  dsc_instruction_format_decoder uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .peek_word(peek_word),
    .fetch_ready(fetch_ready), .cond_true(cond_true), .dec_valid(dec_valid),
    .dec_nop(dec_nop), .dec(dec));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // runs far past any scenario; a hang ends here
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask

  // loads up to two words, then counts decodes and inserted no-ops
  task automatic exec(input logic [23:0] a, input logic [23:0] b, input int n, input logic c);
    @(posedge clk);
    load_w0 <= a;
    load_w1 <= b;
    load_len <= 3'(n);
    load <= 1'b1;
    cond_true <= c;
    got = 0;
    nops = 0;
    @(posedge clk);
    load <= 1'b0;
    repeat (10)
    begin
      @(negedge clk);
      if (dec_valid === 1'b1)
      begin
        got++;
        d = dec;
      end
      if (dec_nop === 1'b1)
        nops++;
    end
  endtask

  task automatic t_file;
    exec(24'h13ffff, 24'h0, 1, 0);
    chk("got", 32'(got), 1);
    chk("cls", 32'(d.cls), 32'(CLS_FILE));
    chk("opcode", 32'(d.opcode), 8'h13);
    chk("file_addr", 32'(d.file_addr), 13'h1fff);
    chk("to_default_working_reg", 32'(d.dest_to_default_working_reg), 1);
    chk("cycles", 32'(d.cycles), 1);
    chk("carry_upd", 32'(d.flags.carry), 1);
    exec(24'h10dfff, 24'h0, 1, 0);
    chk("to_file", 32'(d.dest_to_default_working_reg), 0);
    chk("file_addr_top", 32'(d.file_addr), 13'h1fff);
    exec(24'hd00000, 24'h0, 1, 0);
    chk("bad_class", 32'(d.illegal), 1);
    @(posedge clk);
    clk_en <= 1'b0;
    @(negedge clk);
    chk("ready_frozen", 32'(fetch_ready), 0);
    @(posedge clk);
    clk_en <= 1'b1;
  endtask

  task automatic t_lit;
    exec(24'h203ff0, 24'h0, 1, 0);
    chk("word_lit", 32'(d.ten_bit_literal), 10'h3ff);
    chk("word_ok", 32'(d.illegal), 0);
    exec(24'h204ff0, 24'h0, 1, 0);
    chk("byte_max_ok", 32'(d.illegal), 0);
    exec(24'h205000, 24'h0, 1, 0);
    chk("byte_over", 32'(d.illegal), 1);
  endtask

  task automatic t_flow;
    exec(24'h500000, 24'h0, 1, 1);
    chk("br_cycles", 32'(d.cycles), 4);
    chk("br_nops", 32'(nops), 3);
    exec(24'h500000, 24'h0, 1, 0);
    chk("nobr_nops", 32'(nops), 0);
    exec(24'h600000, 24'h0, 1, 0);
    chk("jmp_nops", 32'(nops), 3);
    exec(24'h900000, 24'h0, 1, 0);
    chk("tbl_cycles", 32'(d.cycles), 2);
    exec(24'h800000, 24'h0, 1, 0);
    chk("movd_cycles", 32'(d.cycles), 2);
  endtask

  task automatic t_skip;
    exec(24'h400000, 24'h13ffff, 1, 1);
    chk("skip1_cycles", 32'(d.cycles), 2);
    chk("skip1_nops", 32'(nops), 1);
    exec(24'h400000, 24'h701234, 1, 1);
    chk("skip2_cycles", 32'(d.cycles), 3);
    chk("skip2_nops", 32'(nops), 2);
    exec(24'h400000, 24'h701234, 1, 0);
    chk("noskip_nops", 32'(nops), 0);
  endtask

  task automatic t_double;
    exec(24'h701234, 24'h000056, 2, 0);
    chk("dbl_got", 32'(got), 1);
    chk("dbl_addr", 32'(d.program_addr_literal), 23'h561234);
    chk("dbl_cycles", 32'(d.cycles), 2);
    chk("dbl_ok", 32'(d.illegal), 0);
    chk("dbl_nops", 32'(nops), 0);
    exec(24'h701234, 24'h010056, 2, 0);
    chk("second_nonzero", 32'(d.illegal), 1);
    exec(24'h701235, 24'h000056, 2, 0);
    chk("odd_addr", 32'(d.illegal), 1);
    exec(24'h000056, 24'h0, 1, 0);
    chk("lone_second", 32'(d.cls), 32'(CLS_NOP));
  endtask

  task automatic t_dsp;
    exec(24'ha00000, 24'h0, 1, 0);
    chk("mul_a", 32'(d.mul_a), 4);
    chk("mul_b", 32'(d.mul_b), 5);
    chk("x_dest", 32'(d.x_prefetch_dest), 4);
    chk("x_base", 32'(d.x_prefetch_addr_sel.base_reg), 8);
    chk("acc_a", 32'(d.acc_sel), 0);
    chk("oa_upd", 32'(d.flags.acc_a_ovf), 1);
    exec(24'ha187f0, 24'h0, 1, 0);
    chk("acc_b", 32'(d.acc_sel), 1);
    chk("awb", 32'(d.acc_writeback_target), 32'(AWB_W13_IND_POSTINC));
    chk("x_idx", 32'(d.x_prefetch_addr_sel.indexed), 1);
    chk("x_idx_base", 32'(d.x_prefetch_addr_sel.base_reg), 9);
    chk("y_none", 32'(d.y_prefetch_addr_sel.none), 1);
    exec(24'ha05010, 24'h0, 1, 0);
    chk("pair5_b", 32'(d.mul_b), 7);
    chk("y_base", 32'(d.y_prefetch_addr_sel.base_reg), 4'ha);
    chk("y_adj", 32'(d.y_prefetch_addr_sel.adjust), 4'h2);
    exec(24'ha0e000, 24'h0, 1, 0);
    chk("pair6", 32'(d.illegal), 1);
    exec(24'hb03000, 24'h0, 1, 0);
    chk("sqr_a", 32'(d.mul_a), 7);
    exec(24'hc08000, 24'h0, 1, 0);
    chk("acc_op_b", 32'(d.acc_sel), 1);
    chk("sb_upd", 32'(d.flags.acc_b_sat), 1);
    chk("acc_no_c", 32'(d.flags.carry), 0);
  endtask

  task automatic t_bit;
    exec(24'h30050f, 24'h0, 1, 0);
    chk("bit_pos", 32'(d.bit_position_field), 4'hf);
    chk("bit_base", 32'(d.base_operand_reg), 5);
    chk("bit_dir", 32'(d.bit_indirect), 0);
    exec(24'h300510, 24'h0, 1, 0);
    chk("bit_ind", 32'(d.bit_indirect), 1);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_file();
    t_lit();
    t_flow();
    t_skip();
    t_double();
    t_dsp();
    t_bit();
    report_and_stop();
  end
endmodule

`default_nettype wire
